/* File: nda_pkg.sv */
/*
 * Constants, register map and state encoding of the upstream D-channel arbiter.
 * Assumes one 25 MHz system clock; the host serial bus runs on its own bit clock, sampled here.
 */
`default_nettype none

package nda_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Frame layout, MSB of each octet first
	localparam int unsigned FRAME_SLOTS   = 12;
	localparam int unsigned BITS_PER_SLOT = 8;
	localparam logic [6:0]  POS_D_FIRST   = 7'h18;
	localparam logic [6:0]  POS_D_SECOND  = 7'h19;
	localparam logic [6:0]  POS_CTRL_BIT  = 7'h5A;
	localparam logic [6:0]  POS_LAST      = 7'h5F;

	////////////////////////////////////////////////////////////////////////////////
	// Priority counts
	localparam logic [3:0] N_CLASS_LOW  = 4'h8;
	localparam logic [3:0] N_CLASS_HIGH = 4'hA;
	localparam logic [3:0] ABORT_ONES   = 4'h7;
	localparam int unsigned CNT_W       = 4;

	////////////////////////////////////////////////////////////////////////////////
	// Mode encodings
	localparam logic [1:0] MODE_INT_NT  = 2'h3;
	localparam logic [2:0] DIM_STOP_GO  = 3'h1;

	////////////////////////////////////////////////////////////////////////////////
	// Register map (byte addresses) and field positions
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam int unsigned CTRL_DIM_LSB  = 4;
	localparam int unsigned CTRL_PRIO     = 8;
	localparam int unsigned CTRL_TE_FMT   = 9;
	localparam int unsigned CTRL_ARB_EN   = 10;
	localparam logic [10:0] CTRL_RESET    = 11'h000;
	localparam logic [10:0] CTRL_MASK     = 11'h777;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Arbiter states, Gray along ready -> go -> transmit -> block -> ready
	typedef enum logic [1:0] {
		NDA_READY = 2'h0,
		NDA_GO    = 2'h1,
		NDA_XMIT  = 2'h3,
		NDA_BLOCK = 2'h2
	} nda_state_t;

endpackage

`default_nettype wire

/* File: nda_sync.sv */
/*
 * Two-flop synchroniser for a bundle of independent levels.
 * Assumes each bit is a slow level or a clock far below the sampling clock.
 */
`default_nettype none

module nda_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clock_in,
	input  wire logic             rstn_in,
	input  wire logic             ce_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_d;

	always_comb
	begin
		meta_d = ce_in ? async_in : meta_q;
		sync_d = ce_in ? meta_q : sync_out;
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			meta_q   <= '1;
			sync_out <= '1;
		end
		else
		begin
			meta_q   <= meta_d;
			sync_out <= sync_d;
		end
	end

endmodule

`default_nettype wire

/* File: nda_ones_counter.sv */
/*
 * Consecutive-ones counter over a strobed bit stream, saturating at its top value.
 * Assumes bit_valid_in is a one-cycle strobe from the same clock.
 */
`default_nettype none

module nda_ones_counter #(
	parameter int unsigned WIDTH = 4
) (
	input  wire logic             clock_in,
	input  wire logic             rstn_in,
	input  wire logic             ce_in,
	input  wire logic             clear_in,
	input  wire logic             bit_valid_in,
	input  wire logic             bit_in,
	output logic      [WIDTH-1:0] count_out
);

	logic [WIDTH-1:0] count_d;

	always_comb
	begin
		count_d = count_out;
		if (clear_in)
			count_d = '0;
		else if (bit_valid_in && !bit_in)
			count_d = '0;
		else if (bit_valid_in && count_out != '1)
			count_d = count_out + WIDTH'(1);
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			count_out <= '0;
		else if (ce_in)
			count_out <= count_d;
	end

endmodule

`default_nettype wire

/* File: nda_arbiter.sv */
/*
 * Upstream D-channel arbiter for intelligent-NT operation, with its AXI4-Lite register slave.
 * Assumes: bit clock, frame sync and upstream data arrive asynchronously and are resampled;
 * one bit per bit-clock rising edge, frame sync marks the first bit; line-side D/echo strobes
 * and the exchange permission bit come from same-clock transceiver logic.
 */
// Our own choices: the register addresses and the AXI4-Lite register port.
`default_nettype none

module nda_arbiter #(
	parameter int unsigned TIMESLOTS   = nda_pkg::FRAME_SLOTS,
	parameter bit          PRIO_ONE_IS_HIGH = 1'b1
) (
	input  wire logic        clock_in,
	input  wire logic        rstn_in,
	input  wire logic        ce_in,
	// Host serial bus
	input  wire logic        bit_clock_in,
	input  wire logic        frame_sync_in,
	input  wire logic        upstream_data_line_in,
	output logic             upstream_data_line_out,
	output logic             upstream_data_line_oe_out,
	output logic             downstream_data_line_out,
	output logic             downstream_data_line_oe_out,
	// Line side and exchange
	input  wire logic        line_d_strobe_in,
	input  wire logic        line_d_in,
	input  wire logic        line_dchannel_active_in,
	input  wire logic        permission_in,
	output logic             echo_out,
	output logic             echo_strobe_out,
	// AXI4-Lite slave
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	localparam int unsigned CW = nda_pkg::CNT_W;

	if (TIMESLOTS != nda_pkg::FRAME_SLOTS)
		$error("Arbitration needs the 12-slot terminal frame");

	////////////////////////////////////////////////////////////////////////////////
	// Pin resampling and bit timing

	logic [2:0] pins_sync;
	logic       dcl_s;
	logic       fsc_s;
	logic       du_s;
	logic       dcl_prev_q;
	logic       fsc_prev_q;
	logic       start_pend_q;
	logic [6:0] bit_pos_q;
	logic       dcl_prev_d;
	logic       fsc_prev_d;
	logic       start_pend_d;
	logic [6:0] bit_pos_d;
	logic       dcl_rise;
	logic       dcl_fall;

	nda_sync #(
		.WIDTH (3)
	) u_sync (
		.clock_in (clock_in),
		.rstn_in  (rstn_in),
		.ce_in    (ce_in),
		.async_in ({bit_clock_in, frame_sync_in, upstream_data_line_in}),
		.sync_out (pins_sync)
	);

	assign dcl_s    = pins_sync[2];
	assign fsc_s    = pins_sync[1];
	assign du_s     = pins_sync[0];
	assign dcl_rise = dcl_s && !dcl_prev_q;
	assign dcl_fall = !dcl_s && dcl_prev_q;

	always_comb
	begin
		dcl_prev_d   = dcl_s;
		fsc_prev_d   = fsc_s;
		start_pend_d = start_pend_q;
		bit_pos_d    = bit_pos_q;
		if (fsc_s && !fsc_prev_q)
			start_pend_d = 1'b1;
		if (dcl_rise)
		begin
			if (start_pend_q)
			begin
				bit_pos_d    = '0;
				start_pend_d = 1'b0;
			end
			else if (bit_pos_q != nda_pkg::POS_LAST)
				bit_pos_d = bit_pos_q + 7'h01;
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			// Same level as the synchroniser's reset, so no false edge follows reset
			dcl_prev_q   <= 1'b1;
			fsc_prev_q   <= 1'b1;
			start_pend_q <= 1'b0;
			bit_pos_q    <= nda_pkg::POS_LAST;
		end
		else if (ce_in)
		begin
			dcl_prev_q   <= dcl_prev_d;
			fsc_prev_q   <= fsc_prev_d;
			start_pend_q <= start_pend_d;
			bit_pos_q    <= bit_pos_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control register and mode decode

	logic [10:0] ctrl_q;
	logic        arb_active;
	logic        class_high;
	logic [CW-1:0] ones_cnt;
	logic [CW-1:0] n_req;
	logic        last_ok_q;
	logic        aborted_q;
	logic        bac_q;
	logic        d_sample;

	assign arb_active = ctrl_q[nda_pkg::CTRL_TE_FMT] && ctrl_q[nda_pkg::CTRL_ARB_EN]
		&& (ctrl_q[nda_pkg::CTRL_MODE_LSB+1 +: 2] == nda_pkg::MODE_INT_NT)
		&& (ctrl_q[nda_pkg::CTRL_DIM_LSB +: 3] == nda_pkg::DIM_STOP_GO);
	assign class_high = ctrl_q[nda_pkg::CTRL_PRIO] == PRIO_ONE_IS_HIGH;
	assign n_req      = (class_high ? nda_pkg::N_CLASS_HIGH : nda_pkg::N_CLASS_LOW)
		+ {{(CW-1){1'b0}}, last_ok_q};
	assign d_sample   = dcl_fall && (bit_pos_q == nda_pkg::POS_D_FIRST || bit_pos_q == nda_pkg::POS_D_SECOND);

	////////////////////////////////////////////////////////////////////////////////
	// Arbitration state machine

	nda_pkg::nda_state_t state_q;
	nda_pkg::nda_state_t state_d;
	logic                last_ok_d;
	logic                aborted_d;
	logic                bac_d;
	logic                cnt_clear;

	nda_ones_counter #(
		.WIDTH (CW)
	) u_ones (
		.clock_in     (clock_in),
		.rstn_in      (rstn_in),
		.ce_in        (ce_in),
		.clear_in     (cnt_clear),
		.bit_valid_in (d_sample),
		.bit_in       (du_s),
		.count_out    (ones_cnt)
	);

	always_comb
	begin
		state_d   = state_q;
		last_ok_d = last_ok_q;
		aborted_d = aborted_q;
		bac_d     = bac_q;
		cnt_clear = 1'b0;
		if (dcl_fall && bit_pos_q == nda_pkg::POS_CTRL_BIT)
			bac_d = du_s;
		if (!arb_active)
			state_d = nda_pkg::NDA_READY;
		else if (!permission_in)
			state_d = nda_pkg::NDA_BLOCK;
		else
		begin
			case (state_q)
				nda_pkg::NDA_READY:
					if (ones_cnt >= n_req)
						state_d = bac_q ? nda_pkg::NDA_GO : nda_pkg::NDA_XMIT;
				nda_pkg::NDA_GO:
					if (!bac_q)
					begin
						state_d   = nda_pkg::NDA_XMIT;
						aborted_d = 1'b0;
					end
				nda_pkg::NDA_XMIT:
				begin
					// Seven ones inside a held frame can only be an abort
					if (!bac_q && ones_cnt >= nda_pkg::ABORT_ONES)
						aborted_d = 1'b1;
					if (bac_q)
					begin
						state_d   = nda_pkg::NDA_READY;
						last_ok_d = !aborted_q;
						cnt_clear = 1'b1;
					end
				end
				default:
					state_d = nda_pkg::NDA_READY;
			endcase
		end
		// Ones counted before the grant must not mark a good frame as aborted
		if (state_q != nda_pkg::NDA_XMIT && state_d == nda_pkg::NDA_XMIT)
		begin
			aborted_d = 1'b0;
			cnt_clear = 1'b1;
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			state_q   <= nda_pkg::NDA_READY;
			last_ok_q <= 1'b0;
			aborted_q <= 1'b0;
			bac_q     <= 1'b1;
		end
		else if (ce_in)
		begin
			state_q   <= state_d;
			last_ok_q <= last_ok_d;
			aborted_q <= aborted_d;
			bac_q     <= bac_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin drive: stop/go downstream, line D upstream, echo to the line

	logic sg_bit;
	logic echo_inv;
	logic line_d_q;
	logic line_d_d;
	logic dd_d;
	logic dd_oe_d;
	logic du_d;
	logic du_oe_d;
	logic echo_d;
	logic echo_stb_d;

	// Stop while ready or blocked; go in idle and during a held frame
	assign sg_bit   = (state_q == nda_pkg::NDA_READY || state_q == nda_pkg::NDA_BLOCK);
	assign echo_inv = (state_q == nda_pkg::NDA_XMIT || state_q == nda_pkg::NDA_BLOCK);

	always_comb
	begin
		line_d_d   = line_d_strobe_in ? line_d_in : line_d_q;
		dd_d       = downstream_data_line_out;
		dd_oe_d    = downstream_data_line_oe_out;
		du_d       = upstream_data_line_out;
		du_oe_d    = upstream_data_line_oe_out;
		if (dcl_rise)
		begin
			dd_oe_d = arb_active && bit_pos_d == nda_pkg::POS_CTRL_BIT;
			dd_d    = dd_oe_d ? sg_bit : 1'b1;
			// Line data must not collide with a bus-side frame
			du_oe_d = line_dchannel_active_in && state_q != nda_pkg::NDA_XMIT
				&& (bit_pos_d == nda_pkg::POS_D_FIRST || bit_pos_d == nda_pkg::POS_D_SECOND);
			du_d    = du_oe_d ? line_d_q : 1'b1;
		end
		echo_stb_d = line_d_strobe_in;
		echo_d     = line_d_strobe_in ? (line_d_in ^ echo_inv) : echo_out;
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			line_d_q                    <= 1'b1;
			downstream_data_line_out    <= 1'b1;
			downstream_data_line_oe_out <= 1'b0;
			upstream_data_line_out      <= 1'b1;
			upstream_data_line_oe_out   <= 1'b0;
			echo_out                    <= 1'b1;
			echo_strobe_out             <= 1'b0;
		end
		else if (ce_in)
		begin
			line_d_q                    <= line_d_d;
			downstream_data_line_out    <= dd_d;
			downstream_data_line_oe_out <= dd_oe_d;
			upstream_data_line_out      <= du_d;
			upstream_data_line_oe_out   <= du_oe_d;
			echo_out                    <= echo_d;
			echo_strobe_out             <= echo_stb_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	logic        aw_have_q;
	logic        w_have_q;
	logic [3:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        aw_have_d;
	logic        w_have_d;
	logic [3:0]  aw_addr_d;
	logic [31:0] w_data_d;
	logic [3:0]  w_strb_d;
	logic [10:0] ctrl_d;
	logic        awready_d;
	logic        wready_d;
	logic        bvalid_d;
	logic [1:0]  bresp_d;
	logic        arready_d;
	logic        rvalid_d;
	logic [1:0]  rresp_d;
	logic [31:0] rdata_d;
	logic [31:0] status_word;
	logic [31:0] wmerge;
	logic        do_write;

	assign status_word = {15'h0000, permission_in, arb_active, aborted_q, sg_bit, bac_q, n_req, ones_cnt,
		2'h0, state_q};
	assign wmerge = {w_strb_q[3] ? w_data_q[31:24] : 8'h00, w_strb_q[2] ? w_data_q[23:16] : 8'h00,
		w_strb_q[1] ? w_data_q[15:8] : {5'h00, ctrl_q[10:8]}, w_strb_q[0] ? w_data_q[7:0] : ctrl_q[7:0]};
	assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

	always_comb
	begin
		aw_have_d = aw_have_q;
		w_have_d  = w_have_q;
		aw_addr_d = aw_addr_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		ctrl_d    = ctrl_q;
		bvalid_d  = s_axi_bvalid && !s_axi_bready;
		bresp_d   = s_axi_bresp;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_have_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_have_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		if (do_write)
		begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = nda_pkg::RESP_OKAY;
			if (aw_addr_q == nda_pkg::ADDR_CTRL)
				ctrl_d = wmerge[10:0] & nda_pkg::CTRL_MASK;
			else if (aw_addr_q != nda_pkg::ADDR_STATUS)
				bresp_d = nda_pkg::RESP_SLVERR;
		end
		awready_d = !aw_have_d && !bvalid_d;
		wready_d  = !w_have_d && !bvalid_d;
		rvalid_d  = s_axi_rvalid && !s_axi_rready;
		rdata_d   = s_axi_rdata;
		rresp_d   = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_d = 1'b1;
			rresp_d  = nda_pkg::RESP_OKAY;
			if (s_axi_araddr == nda_pkg::ADDR_CTRL)
				rdata_d = {21'h000000, ctrl_q};
			else if (s_axi_araddr == nda_pkg::ADDR_STATUS)
				rdata_d = status_word;
			else
			begin
				rdata_d = 32'h00000000;
				rresp_d = nda_pkg::RESP_SLVERR;
			end
		end
		arready_d = !rvalid_d;
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			aw_addr_q     <= 4'h0;
			w_data_q      <= 32'h00000000;
			w_strb_q      <= 4'h0;
			ctrl_q        <= nda_pkg::CTRL_RESET;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= nda_pkg::RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= nda_pkg::RESP_OKAY;
			s_axi_rdata   <= 32'h00000000;
		end
		else if (ce_in)
		begin
			aw_have_q     <= aw_have_d;
			w_have_q      <= w_have_d;
			aw_addr_q     <= aw_addr_d;
			w_data_q      <= w_data_d;
			w_strb_q      <= w_strb_d;
			ctrl_q        <= ctrl_d;
			s_axi_awready <= awready_d;
			s_axi_wready  <= wready_d;
			s_axi_bvalid  <= bvalid_d;
			s_axi_bresp   <= bresp_d;
			s_axi_arready <= arready_d;
			s_axi_rvalid  <= rvalid_d;
			s_axi_rresp   <= rresp_d;
			s_axi_rdata   <= rdata_d;
		end
	end

endmodule

`default_nettype wire

/* File: nda_arbiter_monitor.sv */
/* Port-level checks on the upstream D-channel arbiter.
   Assumes one system clock domain and an AXI master that offers address and data together. */
`default_nettype none

module nda_arbiter_monitor (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic line_d_strobe_in,
	input wire logic echo_strobe_out,
	input wire logic permission_in,
	input wire logic line_dchannel_active_in,
	input wire logic upstream_data_line_oe_out,
	input wire logic downstream_data_line_out,
	input wire logic downstream_data_line_oe_out,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rstn_in);

	////////////////////////////////////////////////////////////////////////////////
	echo_pulse_a:
		assert property (line_d_strobe_in |=> echo_strobe_out) else $error("echo strobe late");
	dd_idle_high_a:
		assert property (!downstream_data_line_oe_out |-> downstream_data_line_out) else $error("released dd low");
	dd_bit_width_a:
		assert property ($rose(downstream_data_line_oe_out) |-> downstream_data_line_oe_out[*6] ##[1:4]
			!downstream_data_line_oe_out) else $error("stop/go not one bit wide");
	dd_steady_a:
		assert property (downstream_data_line_oe_out && $past(downstream_data_line_oe_out)
			|-> $stable(downstream_data_line_out)) else $error("stop/go changed in its bit");
	// Sixteen cycles cover a bit period plus resampling, so the bit was formed after the block began
	block_stop_a:
		assert property (downstream_data_line_oe_out && !permission_in && !$past(permission_in, 16)
			|-> downstream_data_line_out) else $error("go while blocked");
	du_line_only_a:
		assert property ($rose(upstream_data_line_oe_out) |-> line_dchannel_active_in) else $error("du driven idle");
	write_answer_a:
		assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid) else $error("no write answer");
	read_answer_a:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");

endmodule

bind nda_arbiter nda_arbiter_monitor u_nda_arbiter_monitor (.clock_in(clock_in), .rstn_in(rstn_in),
	.line_d_strobe_in(line_d_strobe_in), .echo_strobe_out(echo_strobe_out), .permission_in(permission_in),
	.line_dchannel_active_in(line_dchannel_active_in), .upstream_data_line_oe_out(upstream_data_line_oe_out),
	.downstream_data_line_out(downstream_data_line_out), .downstream_data_line_oe_out(downstream_data_line_oe_out),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

`default_nettype wire

/* File: nda_bus_model.sv */
/* Host serial bus timing plus one local HDLC controller.
   Assumes pull-ups on both data lines; the bench wire-ANDs the arbiter's drive in. */
`default_nettype none

module nda_bus_model (
	input  wire logic       request_in,
	input  wire logic       abort_in,
	input  wire logic       up_line_in,
	input  wire logic       down_line_in,
	output logic            bit_clock_out,
	output logic            frame_sync_out,
	output logic            up_drive_out,
	output logic            stop_go_out,
	output logic      [1:0] d_seen_out
);
	timeunit 1ns;
	timeprecision 1ps;

	int   pos;
	logic bac;
	logic free;

	initial
	begin
		pos = 94;
		bac = 1'b1;
		free = 1'b1;
		bit_clock_out = 1'b0;
		frame_sync_out = 1'b0;
		up_drive_out = 1'b1;
		stop_go_out = 1'b1;
		d_seen_out = 2'h3;
		forever
		begin
			#160;
			pos = (pos == 95) ? 0 : pos + 1;
			bit_clock_out = 1'b1;
			if (pos == 90)
				bac = !request_in ? 1'b1 : (free ? 1'b0 : bac);
			if (pos == 90)
				up_drive_out = bac;
			else if ((pos == 24 || pos == 25) && !bac && !stop_go_out)
				up_drive_out = (pos == 25) || abort_in;
			else
				up_drive_out = 1'b1;
			#160;
			bit_clock_out = 1'b0;
			if (pos == 90)
				free = up_line_in;
			if (pos == 90)
				stop_go_out = down_line_in;
			if (pos == 24)
				d_seen_out[1] = up_line_in;
			if (pos == 25)
				d_seen_out[0] = up_line_in;
			frame_sync_out = (pos == 95);
		end
	end

endmodule

`default_nettype wire

/* File: nda_arbiter_test.sv */
/* Self-checking bench for the upstream D-channel arbiter.
   Assumes the bus model for the host bus and a bind of the port monitor. */
`default_nettype none

module nda_arbiter_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clock_in, rstn_in, bclk, fsync, du_m, sg, req, abt, lstb, ld, lact, perm;
	logic        du_o, du_oe, dd_o, dd_oe, echo, estb;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0]  dseen, bresp, rresp;
	logic [3:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [15:0] seed;
	logic [67:0] e;
	logic        eq[$];
	logic [67:0] aq[$];
	int          bad_count, n_tests, frames;
	wire logic   du_w = du_m & (du_oe ? du_o : 1'b1);
	wire logic   dd_w = dd_oe ? dd_o : 1'b1;

	nda_bus_model u_nda_bus_model (.request_in(req), .abort_in(abt), .up_line_in(du_w), .down_line_in(dd_w),
		.bit_clock_out(bclk), .frame_sync_out(fsync), .up_drive_out(du_m), .stop_go_out(sg), .d_seen_out(dseen));

	nda_arbiter u_nda_arbiter (.clock_in(clock_in), .rstn_in(rstn_in), .ce_in(1'b1), .bit_clock_in(bclk),
		.frame_sync_in(fsync), .upstream_data_line_in(du_w), .upstream_data_line_out(du_o),
		.upstream_data_line_oe_out(du_oe), .downstream_data_line_out(dd_o), .downstream_data_line_oe_out(dd_oe),
		.line_d_strobe_in(lstb), .line_d_in(ld), .line_dchannel_active_in(lact), .permission_in(perm),
		.echo_out(echo), .echo_strobe_out(estb), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	initial
	begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end

	always @(posedge fsync) frames++;

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string what);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic give_up();
		bad_count++;
		report_and_stop();
	endtask

	// Expected results are queued before the request so the watcher never pops early
	always @(posedge clock_in)
	begin
		if (estb === 1'b1)
			check({33'h0, echo}, {33'h0, eq.pop_front()}, "echo");
		if (bvalid === 1'b1 && bready === 1'b1)
		begin
			e = aq.pop_front();
			check({bresp, 32'h0} & e[67:34], e[33:0], "write response");
		end
		if (rvalid === 1'b1 && rready === 1'b1)
		begin
			e = aq.pop_front();
			check({rresp, rdata} & e[67:34], e[33:0], "read data");
		end
	end

	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		int i;
		@(posedge clock_in);
		aq.push_back({2'h3, 32'h0, r, 32'h0});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge clock_in);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
				break;
		end
		bready <= 1'b0;
		if (i == 50)
			give_up();
	endtask

	task automatic axi_read(input logic [3:0] a, input logic [1:0] r, input logic [31:0] d, input logic [31:0] m);
		int i;
		@(posedge clock_in);
		aq.push_back({2'h3, m, r, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge clock_in);
			if (arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
				break;
		end
		rready <= 1'b0;
		if (i == 50)
			give_up();
	endtask

	task automatic wait_frames(input int k);
		int t;
		int i;
		t = frames + k;
		for (i = 0; i < 1000 * k && frames < t; i++)
			@(posedge clock_in);
		if (frames < t)
			give_up();
	endtask

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic send_line(input int k, input logic inv, input logic m);
		repeat (k)
		begin
			@(posedge clock_in);
			seed = lfsr_next(seed);
			ld <= seed[0] & m;
			lstb <= 1'b1;
			eq.push_back((seed[0] & m) ^ inv);
			@(posedge clock_in);
			lstb <= 1'b0;
		end
	endtask

	task automatic transfer(input int n);
		int k;
		for (k = 0; k < 10 && sg !== 1'b0; k++)
			wait_frames(1);
		check({33'h0, sg}, 34'h0, "go after ones");
		req <= 1'b1;
		// An even count means the held frame ends in an abort
		abt <= (n % 2 == 0);
		wait_frames(10);
		axi_read(nda_pkg::ADDR_STATUS, nda_pkg::RESP_OKAY, 32'h8003, 32'hA003);
		send_line(4, 1'b1, 1'b1);
		req <= 1'b0;
		abt <= 1'b0;
		for (k = 0; k < 10 && sg !== 1'b1; k++)
			wait_frames(1);
		for (k = 1; k < 20; k++)
		begin
			wait_frames(1);
			if (sg === 1'b0)
				break;
		end
		check(34'(k), 34'((n - 1) / 2), "frames held at stop");
		axi_read(nda_pkg::ADDR_STATUS, nda_pkg::RESP_OKAY, 32'(n) << 8, 32'h0F00);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		{rstn_in, req, abt, lstb, ld, lact, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		perm = 1'b1;
		seed = 16'hD765;
		repeat (4) @(posedge clock_in);
		rstn_in <= 1'b1;
		axi_read(nda_pkg::ADDR_CTRL, nda_pkg::RESP_OKAY, 32'h0, 32'hFFFFFFFF);
		axi_read(4'h8, nda_pkg::RESP_SLVERR, 32'h0, 32'hFFFFFFFF);
		axi_write(4'hC, 32'h0, nda_pkg::RESP_SLVERR);
		axi_write(nda_pkg::ADDR_CTRL, 32'hFFFFFFFF, nda_pkg::RESP_OKAY);
		axi_read(nda_pkg::ADDR_CTRL, nda_pkg::RESP_OKAY, {21'h0, nda_pkg::CTRL_MASK}, 32'hFFFFFFFF);
		// Class 8, NT machine, stop/go evaluation, 12-slot frame, arbitration on
		axi_write(nda_pkg::ADDR_CTRL, 32'h616, nda_pkg::RESP_OKAY);
		send_line(4, 1'b0, 1'b1);
		lact <= 1'b1;
		send_line(1, 1'b0, 1'b0);
		wait_frames(2);
		check({32'h0, dseen}, 34'h0, "line data upstream");
		lact <= 1'b0;
		transfer(9);
		axi_write(nda_pkg::ADDR_CTRL, 32'h716, nda_pkg::RESP_OKAY);
		transfer(11);
		transfer(10);
		perm <= 1'b0;
		wait_frames(2);
		check({33'h0, sg}, 34'h1, "stop while blocked");
		axi_read(nda_pkg::ADDR_STATUS, nda_pkg::RESP_OKAY, 32'h8002, 32'h18003);
		send_line(4, 1'b1, 1'b1);
		perm <= 1'b1;
		wait_frames(1);
		report_and_stop();
	end

endmodule

`default_nettype wire
